// ---- logic/dcc_arbiter.sv ----
`timescale 1ns/1ps
`include "dcc_cfg.svh"
module dcc_arbiter (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [3:0] req,
  input wire logic [2:0] priority_select,
  input wire logic bus_release_cond,
  input wire logic channel_change_cond,
  input wire logic cycle_end,
  output logic bus_own,
  output logic [3:0] grant
);
  import dcc_pkg::*;

  typedef struct packed {
    logic owned;
    logic [1:0] cur;
    logic [3:0] served;
    logic [3:0] round;
    logic [1:0] rot;
  } dcc_arb_t;

  dcc_arb_t s;
  dcc_arb_t next_s;

  // ==========================================================
  // Priority pick
  function automatic logic [1:0] pick(input logic [3:0] m, input logic [2:0] sel,
                                      input logic [1:0] rot);
    logic [7:0] order;
    logic [1:0] ch;
    logic found;
    pick = 2'h0;
    found = 1'b0;
    case (sel[1:0])
      2'h0: order = `DCC_ORDER_0;
      2'h1: order = `DCC_ORDER_1;
      2'h2: order = `DCC_ORDER_2;
      default: order = `DCC_ORDER_3;
    endcase
    for (int i = 0; i < 4; i++) begin
      if (sel[`DCC_PR_ROTATE]) begin
        ch = rot + i[1:0];
      end else begin
        ch = order[2*i +: 2];
      end
      if (!found && m[ch]) begin
        pick = ch;
        found = 1'b1;
      end
    end
  endfunction

  // ==========================================================
  // Ownership and channel switching
  always_comb begin
    logic [3:0] curbit;
    logic [3:0] done;
    logic [3:0] others;
    logic [3:0] cand;
    logic rot_round;
    next_s = s;
    curbit = 4'h1 << s.cur;
    done = s.served | curbit;
    others = req & ~curbit;
    cand = 4'h0;
    rot_round = priority_select[`DCC_PR_ROTATE] & channel_change_cond;
    if (!s.owned) begin
      if (|req) begin
        next_s.owned = 1'b1;
        next_s.round = req;
        next_s.served = 4'h0;
        next_s.cur = pick(req, priority_select, s.rot);
      end
    end else if (cycle_end) begin
      next_s.served = done;
      next_s.rot = s.cur + 2'h1;
      if (bus_release_cond) begin
        cand = rot_round ? (req & s.round & ~done) : (req & ~done);
      end else if (channel_change_cond && req[s.cur]) begin
        cand = curbit;
      end else begin
        cand = (|others) ? others : req;
      end
      if (|cand) begin
        next_s.cur = pick(cand, priority_select, s.cur + 2'h1);
      end else if (bus_release_cond && rot_round && |req) begin
        next_s.served = 4'h0;
        next_s.round = req;
        next_s.cur = pick(req, priority_select, s.cur + 2'h1);
      end else begin
        next_s.owned = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign bus_own = s.owned;
  assign grant = s.owned ? (4'h1 << s.cur) : 4'h0;
endmodule

// ---- logic/dcc_bus_if.sv ----
`timescale 1ns/1ps
interface dcc_bus_if;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic normal_end_irq;
  logic error_irq;
  modport dev (input addr, wdata, wr, rd, output rdata, normal_end_irq, error_irq);
  modport host (output addr, wdata, wr, rd, input rdata, normal_end_irq, error_irq);
endinterface

// ---- logic/dcc_cfg.svh ----
`ifndef DCC_CFG_SVH
`define DCC_CFG_SVH

// ==========================================================
// Register map (byte addresses, 7-bit)
`define DCC_CH_STRIDE 7'h10
`define DCC_OFF_STATUS 4'h0
`define DCC_OFF_MODE 4'h1
`define DCC_OFF_IRQ_EN 4'h2
`define DCC_OFF_CMD 4'h3
`define DCC_OFF_FCT 4'h4
`define DCC_ADDR_PRIO 7'h40
`define DCC_ADDR_GEN 7'h41

// ==========================================================
// Field positions
`define DCC_ST_XFER_END 7
`define DCC_ST_FRAME_END 6
`define DCC_ST_BUF_OVF 5
`define DCC_ST_CNT_OVF 4
`define DCC_ST_ENABLE 1
`define DCC_ST_WR_EN_N 0
`define DCC_MD_CHAINED 4
`define DCC_MD_CNT_EN 1
`define DCC_IE_XFER_END 7
`define DCC_IE_FRAME_END 6
`define DCC_IE_BUF_OVF 5
`define DCC_IE_CNT_OVF 4
`define DCC_PR_BRC 4
`define DCC_PR_CCC 3
`define DCC_PR_ROTATE 2
`define DCC_GEN_MASTER 7

// ==========================================================
// Codes and reset values
`define DCC_CMD_ABORT 2'h1
`define DCC_CMD_FCT_CLR 2'h2
`define DCC_FCT_MAX 4'hF
`define DCC_IE_MASK 8'hF0
`define DCC_MODE_MASK 8'h12
`define DCC_PRIO_MASK 8'h1F
`define DCC_GEN_RESET 1'h1
// Fixed orders, highest priority in the low two bits
`define DCC_ORDER_0 8'hE4
`define DCC_ORDER_1 8'h4E
`define DCC_ORDER_2 8'hD8
`define DCC_ORDER_3 8'h8D

`endif

// ---- logic/dcc_device.sv ----
`timescale 1ns/1ps
`include "dcc_cfg.svh"
// Operation
// - Transfer-end enable gates normal-end interrupt
// - Chained mode frame-end enable gates normal interrupt
// - Chained mode overflow enable gates error interrupt
// - Chained counter-overflow enable; low bits read zero
// - Normal interrupt when flag and enable set
// - Command register always reads zero
// - Abort code resets halted sequencer; only two codes
// - Clear code zeroes counter and frame flag
// - Software aborts before reusing disabled channel
// - Disable moves to halt; abort to initial
// - Software never moves enable state straight to initial
// - Software changes settings only after abort
// - Normal completion returns channel to initial
// - Shared registers accessed byte-wide only
// - Release bus after all requests served
// - Release bit: one transfer per channel
// - Switch after cycle end per change bit
// - Priority field selects fixed or rotating
// - Rotating round serves first requests in order
// - Late higher request waits for round end
// - Release after round unless second request
// - Master enable gates all channels, resets one
module dcc_device (
  input wire logic sys_clk,
  input wire logic srst,
  dcc_bus_if.dev bus,
  input wire logic [3:0] dma_req,
  input wire logic [3:0] xfer_done,
  input wire logic [3:0] frame_done,
  input wire logic [3:0] buf_ovf_evt,
  input wire logic cycle_end,
  output logic [3:0] chan_active,
  output logic bus_own,
  output logic [3:0] grant
);
  import dcc_pkg::*;

  typedef struct packed {
    dcc_chan_state_t [3:0] state;
    logic [3:0] channel_enable;
    logic [3:0] xfer_end_flag;
    logic [3:0] frame_end_flag;
    logic [3:0] buf_ovf_flag;
    logic [3:0] cnt_ovf_flag;
    logic [3:0][7:0] channel_mode_reg;
    logic [3:0][7:0] dma_irq_enable;
    logic [3:0][3:0] frame_end_counter;
    logic [7:0] dma_channel_priority;
    logic master_enable;
    logic [7:0] rdata;
  } dcc_dev_t;

  dcc_dev_t s;
  dcc_dev_t next_s;

  // ==========================================================
  // Address decode
  function automatic logic is_chan(input logic [6:0] a, input logic [1:0] ch,
                                   input logic [3:0] off);
    is_chan = (a[6:4] == {1'b0, ch}) && (a[3:0] == off);
  endfunction

  // ==========================================================
  // Channel sequencers and registers
  always_comb begin
    logic chained;
    logic cnt_en;
    logic [1:0] ch;
    logic [7:0] rd;
    chained = 1'b0;
    cnt_en = 1'b0;
    ch = 2'h0;
    next_s = s;
    rd = 8'h00;
    for (int i = 0; i < 4; i++) begin
      ch = i[1:0];
      chained = s.channel_mode_reg[i][`DCC_MD_CHAINED];
      cnt_en = chained & s.channel_mode_reg[i][`DCC_MD_CNT_EN];
      // Software writes first; hardware events below win over clears
      if (bus.wr && is_chan(bus.addr, ch, `DCC_OFF_STATUS)) begin
        if (bus.wdata[`DCC_ST_XFER_END]) begin
          next_s.xfer_end_flag[i] = 1'b0;
        end
        if (bus.wdata[`DCC_ST_BUF_OVF]) begin
          next_s.buf_ovf_flag[i] = 1'b0;
        end
        if (bus.wdata[`DCC_ST_CNT_OVF]) begin
          next_s.cnt_ovf_flag[i] = 1'b0;
        end
        if (bus.wdata[`DCC_ST_FRAME_END]) begin
          if (cnt_en && s.frame_end_counter[i] != 4'h0) begin
            next_s.frame_end_counter[i] = s.frame_end_counter[i] - 4'h1;
            next_s.frame_end_flag[i] = (s.frame_end_counter[i] != 4'h1);
          end else begin
            next_s.frame_end_flag[i] = 1'b0;
          end
        end
        if (!bus.wdata[`DCC_ST_WR_EN_N]) begin
          next_s.channel_enable[i] = bus.wdata[`DCC_ST_ENABLE];
          if (bus.wdata[`DCC_ST_ENABLE]) begin
            next_s.state[i] = DCC_ENABLED;
          end else if (s.state[i] == DCC_ENABLED) begin
            next_s.state[i] = DCC_HALT;
          end
        end
      end
      if (bus.wr && is_chan(bus.addr, ch, `DCC_OFF_MODE)) begin
        next_s.channel_mode_reg[i] = bus.wdata & `DCC_MODE_MASK;
      end
      if (bus.wr && is_chan(bus.addr, ch, `DCC_OFF_IRQ_EN)) begin
        next_s.dma_irq_enable[i] = bus.wdata & `DCC_IE_MASK;
      end
      if (bus.wr && is_chan(bus.addr, ch, `DCC_OFF_CMD)) begin
        case (bus.wdata[1:0])
          `DCC_CMD_ABORT: begin
            if (s.state[i] == DCC_HALT) begin
              next_s.state[i] = DCC_INIT;
            end
          end
          `DCC_CMD_FCT_CLR: begin
            next_s.frame_end_counter[i] = 4'h0;
            next_s.frame_end_flag[i] = 1'b0;
          end
          default: begin
          end
        endcase
      end
      // Hardware events
      if (s.state[i] == DCC_ENABLED) begin
        if (frame_done[i] && chained) begin
          next_s.frame_end_flag[i] = 1'b1;
          if (cnt_en) begin
            if (s.frame_end_counter[i] == `DCC_FCT_MAX) begin
              next_s.frame_end_counter[i] = 4'h0;
              next_s.cnt_ovf_flag[i] = 1'b1;
              next_s.channel_enable[i] = 1'b0;
              next_s.state[i] = DCC_INIT;
            end else begin
              next_s.frame_end_counter[i] = s.frame_end_counter[i] + 4'h1;
            end
          end
        end
        if (buf_ovf_evt[i] && chained) begin
          next_s.buf_ovf_flag[i] = 1'b1;
          next_s.channel_enable[i] = 1'b0;
          next_s.state[i] = DCC_INIT;
        end
        if (xfer_done[i]) begin
          next_s.xfer_end_flag[i] = 1'b1;
          next_s.channel_enable[i] = 1'b0;
          next_s.state[i] = DCC_INIT;
        end
      end
      // Read mux
      if (is_chan(bus.addr, ch, `DCC_OFF_STATUS)) begin
        rd = {s.xfer_end_flag[i], s.frame_end_flag[i], s.buf_ovf_flag[i],
              s.cnt_ovf_flag[i], 2'h0, s.channel_enable[i], 1'b1};
      end else if (is_chan(bus.addr, ch, `DCC_OFF_MODE)) begin
        rd = s.channel_mode_reg[i];
      end else if (is_chan(bus.addr, ch, `DCC_OFF_IRQ_EN)) begin
        rd = s.dma_irq_enable[i];
      end else if (is_chan(bus.addr, ch, `DCC_OFF_CMD)) begin
        rd = 8'h00;
      end else if (is_chan(bus.addr, ch, `DCC_OFF_FCT)) begin
        rd = {4'h0, s.frame_end_counter[i]};
      end
    end
    if (bus.wr && bus.addr == `DCC_ADDR_PRIO) begin
      next_s.dma_channel_priority = bus.wdata & `DCC_PRIO_MASK;
    end
    if (bus.wr && bus.addr == `DCC_ADDR_GEN) begin
      next_s.master_enable = bus.wdata[`DCC_GEN_MASTER];
    end
    if (bus.addr == `DCC_ADDR_PRIO) begin
      rd = s.dma_channel_priority;
    end else if (bus.addr == `DCC_ADDR_GEN) begin
      rd = {s.master_enable, 7'h00};
    end
    next_s.rdata = bus.rd ? rd : 8'h00;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s <= '0;
      s.master_enable <= `DCC_GEN_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Interrupt outputs
  always_comb begin
    logic nrm;
    logic err;
    logic chained;
    chained = 1'b0;
    nrm = 1'b0;
    err = 1'b0;
    for (int i = 0; i < 4; i++) begin
      chained = s.channel_mode_reg[i][`DCC_MD_CHAINED];
      nrm = nrm | (s.xfer_end_flag[i] & s.dma_irq_enable[i][`DCC_IE_XFER_END]);
      nrm = nrm | (chained & s.frame_end_flag[i]
                   & s.dma_irq_enable[i][`DCC_IE_FRAME_END]);
      err = err | (chained & s.buf_ovf_flag[i] & s.dma_irq_enable[i][`DCC_IE_BUF_OVF]);
      err = err | (chained & s.cnt_ovf_flag[i] & s.dma_irq_enable[i][`DCC_IE_CNT_OVF]);
    end
    bus.normal_end_irq = nrm;
    bus.error_irq = err;
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      chan_active[i] = s.master_enable && s.channel_enable[i]
                       && (s.state[i] == DCC_ENABLED);
    end
  end

  assign bus.rdata = s.rdata;

  dcc_arbiter u_arb (
    .sys_clk(sys_clk),
    .srst(srst),
    .req(dma_req & chan_active),
    .priority_select(s.dma_channel_priority[2:0]),
    .bus_release_cond(s.dma_channel_priority[`DCC_PR_BRC]),
    .channel_change_cond(s.dma_channel_priority[`DCC_PR_CCC]),
    .cycle_end(cycle_end),
    .bus_own(bus_own),
    .grant(grant)
  );
endmodule

// ---- logic/dcc_host.sv ----
`timescale 1ns/1ps
`include "dcc_cfg.svh"
module dcc_host (
  input wire logic sys_clk,
  input wire logic srst,
  dcc_bus_if.host bus,
  input wire dcc_pkg::dcc_addr_t sw_addr,
  input wire dcc_pkg::dcc_byte_t sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output dcc_pkg::dcc_byte_t sw_rdata,
  output logic sw_refused,
  output logic normal_end_irq,
  output logic error_irq
);
  import dcc_pkg::*;

  typedef struct packed {
    logic [3:0] halted;
    logic refused;
  } dcc_host_t;

  dcc_host_t s;
  dcc_host_t next_s;
  logic bad;

  // ==========================================================
  // Write screening
  always_comb begin
    logic [1:0] ch;
    logic chan_reg;
    next_s = s;
    ch = sw_addr[5:4];
    chan_reg = !sw_addr[6];
    bad = 1'b0;
    if (sw_wr && chan_reg) begin
      if (sw_addr[3:0] == `DCC_OFF_CMD) begin
        bad = sw_wdata[1:0] != `DCC_CMD_ABORT && sw_wdata[1:0] != `DCC_CMD_FCT_CLR;
      end else if (sw_addr[3:0] == `DCC_OFF_MODE) begin
        bad = s.halted[ch];
      end else if (sw_addr[3:0] == `DCC_OFF_STATUS) begin
        bad = !sw_wdata[`DCC_ST_WR_EN_N] && sw_wdata[`DCC_ST_ENABLE] && s.halted[ch];
      end
      if (!bad && sw_addr[3:0] == `DCC_OFF_STATUS && !sw_wdata[`DCC_ST_WR_EN_N]
          && !sw_wdata[`DCC_ST_ENABLE]) begin
        next_s.halted[ch] = 1'b1;
      end
      if (!bad && sw_addr[3:0] == `DCC_OFF_CMD && sw_wdata[1:0] == `DCC_CMD_ABORT) begin
        next_s.halted[ch] = 1'b0;
      end
    end
    next_s.refused = bad;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Byte-wide accesses only, one register per cycle
  assign bus.addr = sw_addr;
  assign bus.wdata = sw_wdata;
  assign bus.wr = sw_wr && !bad;
  assign bus.rd = sw_rd;
  assign sw_rdata = bus.rdata;
  assign sw_refused = s.refused;
  assign normal_end_irq = bus.normal_end_irq;
  assign error_irq = bus.error_irq;
endmodule

// ---- logic/dcc_pkg.sv ----
package dcc_pkg;
  typedef enum logic [1:0] {DCC_INIT, DCC_ENABLED, DCC_HALT} dcc_chan_state_t;
  typedef logic [6:0] dcc_addr_t;
  typedef logic [7:0] dcc_byte_t;
endpackage

// ---- sim/dcc_bus_properties.sv ----
`timescale 1ns/1ps
`include "dcc_cfg.svh"
module dcc_bus_properties (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [6:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic normal_end_irq,
  input wire logic error_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  wire logic chan_sp = addr < `DCC_ADDR_PRIO;
  wire logic cmd_sel = chan_sp && addr[3:0] == `DCC_OFF_CMD;
  // ======
  // Read port
  property p_rdata_idle;
    !rd |=> rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
  property p_cmd_zero;
    rd && cmd_sel |=> rdata == 8'h00;
  endproperty
  a_cmd_zero: assert property (p_cmd_zero) else $error("command read not zero");
  property p_ie_low;
    rd && chan_sp && addr[3:0] == `DCC_OFF_IRQ_EN |=> rdata[3:0] == 4'h0;
  endproperty
  a_ie_low: assert property (p_ie_low) else $error("irq enable low bits set");
  property p_gen_low;
    rd && addr == `DCC_ADDR_GEN |=> rdata[6:0] == 7'h00;
  endproperty
  a_gen_low: assert property (p_gen_low) else $error("master enable low bits set");
  property p_prio_high;
    rd && addr == `DCC_ADDR_PRIO |=> rdata[7:5] == 3'h0;
  endproperty
  a_prio_high: assert property (p_prio_high) else $error("priority high bits set");
  // ======
  // Writes and interrupts
  property p_one_strobe;
    wr |-> !rd;
  endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("both strobes high");
  property p_cmd_code;
    wr && cmd_sel |-> wdata[1:0] == `DCC_CMD_ABORT || wdata[1:0] == `DCC_CMD_FCT_CLR;
  endproperty
  a_cmd_code: assert property (p_cmd_code) else $error("bad command code");
  property p_frame_clear;
    wr && cmd_sel && wdata[1:0] == `DCC_CMD_FCT_CLR ##2
    rd && addr == {$past(addr[6:4], 2), 4'h0} |=> !rdata[`DCC_ST_FRAME_END];
  endproperty
  a_frame_clear: assert property (p_frame_clear) else $error("frame flag kept");
  property p_norm_fall;
    $fell(normal_end_irq) |-> $past(wr);
  endproperty
  a_norm_fall: assert property (p_norm_fall) else $error("normal irq fell alone");
  property p_err_fall;
    $fell(error_irq) |-> $past(wr);
  endproperty
  a_err_fall: assert property (p_err_fall) else $error("error irq fell alone");
endmodule

// ---- sim/tb_dma_channel_control_arbitration.sv ----
`timescale 1ns/1ps
`include "dcc_cfg.svh"
module tb_dma_channel_control_arbitration;
  import dcc_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  dcc_addr_t sw_addr = 7'h00;
  dcc_byte_t sw_wdata = 8'h00;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic cycle_end = 1'b0;
  logic [3:0] dma_req = 4'h0, xfer_done = 4'h0, frame_done = 4'h0, buf_ovf_evt = 4'h0;
  dcc_byte_t sw_rdata, rv, d;
  logic sw_refused, normal_end_irq, error_irq, bus_own, ref_seen;
  logic [3:0] chan_active, grant, q;
  int n_mismatch = 0;
  int n_compared = 0;
  integer seed = 32'h44d0;
  dcc_bus_if bus_if ();
  dcc_host dcc_host_inst (.sys_clk(sys_clk), .srst(srst), .bus(bus_if.host), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .sw_refused(sw_refused), .normal_end_irq(normal_end_irq), .error_irq(error_irq));
  dcc_device dcc_device_inst (.sys_clk(sys_clk), .srst(srst), .bus(bus_if.dev),
    .dma_req(dma_req), .xfer_done(xfer_done), .frame_done(frame_done),
    .buf_ovf_evt(buf_ovf_evt), .cycle_end(cycle_end), .chan_active(chan_active),
    .bus_own(bus_own), .grant(grant));
  dcc_bus_properties dcc_bus_properties_inst (.sys_clk(sys_clk), .srst(srst),
    .addr(bus_if.addr), .wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd),
    .rdata(bus_if.rdata), .normal_end_irq(bus_if.normal_end_irq), .error_irq(bus_if.error_irq));
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  // ======
  // Helpers
  function automatic dcc_addr_t ra(input int ch, input logic [3:0] off);
    return dcc_addr_t'(ch) * `DCC_CH_STRIDE + {3'h0, off};
  endfunction
  function automatic logic [3:0] pick(input logic [1:0] sel, input logic [3:0] r);
    int ord [4][4] = '{'{0, 1, 2, 3}, '{2, 3, 0, 1}, '{0, 2, 1, 3}, '{1, 3, 0, 2}};
    for (int i = 0; i < 4; i++) begin
      if (r[ord[sel][i]]) return 4'h1 << ord[sel][i];
    end
    return 4'h0;
  endfunction
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input dcc_addr_t a, input dcc_byte_t v);
    @(posedge sys_clk);
    sw_addr <= a;
    sw_wdata <= v;
    sw_wr <= 1'b1;
    @(posedge sys_clk);
    sw_wr <= 1'b0;
    #1 ref_seen = sw_refused;
  endtask
  task automatic rchk(input string what, input dcc_addr_t a, input dcc_byte_t e);
    @(posedge sys_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge sys_clk);
    sw_rd <= 1'b0;
    #1 chk(what, e, sw_rdata);
  endtask
  task automatic pulse(input int k, input logic [3:0] m);
    @(posedge sys_clk);
    case (k)
      0: xfer_done <= m;
      1: frame_done <= m;
      2: buf_ovf_evt <= m;
      default: cycle_end <= m[0];
    endcase
    @(posedge sys_clk);
    {xfer_done, frame_done, buf_ovf_evt, cycle_end} <= '0;
    #1;
  endtask
  task automatic wait_grant(input logic [3:0] g);
    for (int n = 0; n < 8 && grant !== g; n++) @(posedge sys_clk) #1;
    chk("grant", {4'h0, g}, {4'h0, grant});
    chk("bus_own", {7'h0, g != 4'h0}, {7'h0, bus_own});
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_mismatch++;
    stop_test;
  end
  // ======
  // Tests
  initial begin
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    rchk("gen", `DCC_ADDR_GEN, 8'h80);
    rchk("prio", `DCC_ADDR_PRIO, 8'h00);
    rchk("status", ra(0, 0), 8'h01);
    for (int ch = 0; ch < 4; ch++) begin
      d = 8'($random(seed));
      wr(ra(ch, `DCC_OFF_IRQ_EN), d);
      rchk("irq_en", ra(ch, `DCC_OFF_IRQ_EN), d & 8'hF0);
      wr(ra(ch, `DCC_OFF_CMD), 8'h02);
      rchk("cmd", ra(ch, `DCC_OFF_CMD), 8'h00);
    end
    d = 8'($random(seed));
    wr(`DCC_ADDR_PRIO, d);
    rchk("prio", `DCC_ADDR_PRIO, d & 8'h1F);
    wr(7'h60, d);
    rchk("unmapped", 7'h60, 8'h00);
    $display("registers done");
    wr(ra(0, `DCC_OFF_IRQ_EN), 8'h80);
    wr(ra(0, 0), 8'h02);
    pulse(0, 4'h1);
    chk("normal irq", 8'h01, {7'h0, normal_end_irq});
    chk("active", 8'h00, {4'h0, chan_active});
    wr(ra(0, `DCC_OFF_IRQ_EN), 8'h00);
    chk("normal irq", 8'h00, {7'h0, normal_end_irq});
    wr(ra(0, 0), 8'h81);
    rchk("status", ra(0, 0), 8'h01);
    wr(ra(1, `DCC_OFF_MODE), 8'h10);
    wr(ra(1, `DCC_OFF_IRQ_EN), 8'h20);
    wr(ra(1, 0), 8'h02);
    pulse(2, 4'h2);
    chk("error irq", 8'h01, {7'h0, error_irq});
    wr(ra(1, 0), 8'h21);
    chk("error irq", 8'h00, {7'h0, error_irq});
    $display("irq done");
    wr(ra(2, `DCC_OFF_MODE), 8'h12);
    wr(ra(2, `DCC_OFF_IRQ_EN), 8'h50);
    wr(ra(2, 0), 8'h02);
    repeat (3) pulse(1, 4'h4);
    rchk("counter", ra(2, `DCC_OFF_FCT), 8'h03);
    chk("normal irq", 8'h01, {7'h0, normal_end_irq});
    wr(ra(2, `DCC_OFF_CMD), 8'h02);
    rchk("status", ra(2, 0), 8'h03);
    rchk("counter", ra(2, `DCC_OFF_FCT), 8'h00);
    repeat (16) pulse(1, 4'h4);
    chk("error irq", 8'h01, {7'h0, error_irq});
    chk("active", 8'h00, {4'h0, chan_active});
    wr(ra(2, `DCC_OFF_CMD), 8'h02);
    wr(ra(2, 0), 8'h11);
    chk("error irq", 8'h00, {7'h0, error_irq});
    $display("counter done");
    wr(ra(3, 0), 8'h02);
    wr(ra(3, `DCC_OFF_CMD), 8'h01);
    chk("active", 8'h08, {4'h0, chan_active});
    wr(ra(3, 0), 8'h00);
    chk("active", 8'h00, {4'h0, chan_active});
    wr(ra(3, 0), 8'h02);
    chk("refused", 8'h01, {7'h0, ref_seen});
    chk("active", 8'h00, {4'h0, chan_active});
    wr(ra(3, `DCC_OFF_MODE), 8'h10);
    chk("refused", 8'h01, {7'h0, ref_seen});
    wr(ra(3, `DCC_OFF_CMD), 8'h03);
    chk("refused", 8'h01, {7'h0, ref_seen});
    wr(ra(3, `DCC_OFF_CMD), 8'h01);
    wr(ra(3, `DCC_OFF_MODE), 8'h02);
    chk("refused", 8'h00, {7'h0, ref_seen});
    rchk("mode", ra(3, `DCC_OFF_MODE), 8'h02);
    wr(ra(3, 0), 8'h02);
    wr(`DCC_ADDR_GEN, 8'h00);
    chk("active", 8'h00, {4'h0, chan_active});
    wr(`DCC_ADDR_GEN, 8'hFF);
    rchk("gen", `DCC_ADDR_GEN, 8'h80);
    chk("active", 8'h08, {4'h0, chan_active});
    $display("state done");
    for (int ch = 0; ch < 3; ch++) wr(ra(ch, 0), 8'h02);
    for (int s = 0; s < 4; s++) begin
      wr(`DCC_ADDR_PRIO, 8'h08 | 8'(s));
      q = 4'($random(seed)) | (4'h1 << s);
      @(posedge sys_clk);
      dma_req <= q;
      wait_grant(pick(2'(s), q));
      @(posedge sys_clk);
      dma_req <= 4'h0;
      pulse(3, 4'h1);
      wait_grant(4'h0);
    end
    for (int c = 0; c < 3; c++) begin
      wr(`DCC_ADDR_PRIO, c == 0 ? 8'h00 : c == 1 ? 8'h08 : 8'h18);
      @(posedge sys_clk);
      dma_req <= 4'h3;
      wait_grant(4'h1);
      pulse(3, 4'h1);
      repeat (2) @(posedge sys_clk);
      #1 chk("switch", c == 1 ? 8'h01 : 8'h02, {4'h0, grant});
      @(posedge sys_clk);
      dma_req <= 4'h0;
      pulse(3, 4'h1);
      wait_grant(4'h0);
    end
    wr(`DCC_ADDR_PRIO, 8'h1C);
    @(posedge sys_clk);
    dma_req <= 4'hA;
    wait_grant(4'h8);
    pulse(3, 4'h1);
    chk("rotate", 8'h02, {4'h0, grant});
    pulse(3, 4'h1);
    chk("restart", 8'h08, {4'h0, grant});
    @(posedge sys_clk);
    dma_req <= 4'h0;
    pulse(3, 4'h1);
    wait_grant(4'h0);
    $display("arbitration done");
    stop_test;
  end
endmodule
